/* logic/idp_pkg.sv */
// Function
// RULE1: Software waits for running system clock first.
// RULE2: Software sets RAM test mode before access.
// RULE3: Data port is for test use only.
// RULE4: Test mode bit drives all RAMs' test mode.
// RULE5: Ready bit 31 reads 0 busy, 1 idle.
// RULE6: Read ready only after data registers load.
// RULE7: Register writes while busy are discarded.
// RULE8: Done bit 30 sets on success, write-clears.
// RULE9: Response ID echoes the issued command tag.
// RULE10: Response status returns the target's response.
// RULE11: Target select routes DDR2, descriptors, PHY, display.
// RULE12: Auto increment adds transaction size after completion.
// RULE13: Any command write starts; bit 0 direction.
// RULE14: Software loads address and data before command.
// RULE15: Byte enables qualify written bytes.
// RULE16: Address bits 25:0 give the target address.
// RULE17: Low word carries data bits 31:0.
// RULE18: Software checks ready before taking read data.
// RULE19: High word carries data bits 63:32.
// RULE20: Ready clears at start, sets on response.
package idp_pkg;
  localparam int ADDR_W = 16;
  localparam logic [15:0] OFS_SEL = 16'h8000;
  localparam logic [15:0] OFS_CMD = 16'h8004;
  localparam logic [15:0] OFS_ADDR = 16'h8008;
  localparam logic [15:0] OFS_LOW = 16'h800c;
  localparam logic [15:0] OFS_HIGH = 16'h8010;
  localparam int SEL_READY_BIT = 31;
  localparam int SEL_DONE_BIT = 30;
  localparam int SEL_ID_LSB = 20;
  localparam int SEL_RESP_LSB = 16;
  localparam int SEL_TGT_LSB = 4;
  localparam int SEL_AINC_BIT = 1;
  localparam int SEL_TEST_BIT = 0;
  localparam int CMD_BE_LSB = 8;
  localparam int CMD_TAG_LSB = 4;
  localparam int CMD_DIR_BIT = 0;
  localparam logic [5:0] TGT_DDR2 = 6'h00;
  localparam logic [5:0] TGT_DESC = 6'h12;
  localparam logic [5:0] TGT_PHY = 6'h29;
  localparam logic [5:0] TGT_DISP = 6'h2a;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_EXOKAY = 2'h1;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  localparam logic [25:0] INC_DDR2 = 26'h0000008;
  localparam logic [25:0] INC_CSR = 26'h0000004;
  localparam logic [25:0] RST_ADDR = 26'h0000000;
  localparam logic [31:0] RST_WORD = 32'h00000000;

  typedef enum logic [3:0] {
    H_IDLE, H_SEL, H_ADDR, H_LOW, H_HIGH, H_CMD, H_POLL, H_PWAIT,
    H_RLOW, H_RHIGH, H_RLAST, H_FIN
  } idp_hstate_t;

  typedef struct packed {
    logic busy;
    logic tgt_valid;
    logic testen;
    logic ainc;
    logic [5:0] rsel;
    logic done;
    logic [3:0] rid;
    logic [1:0] resp;
    logic [8:0] be;
    logic [3:0] tag;
    logic dir;
    logic [25:0] addr;
    logic [31:0] low;
    logic [31:0] high;
    logic [31:0] rdata;
  } idp_dev_t;

  typedef struct packed {
    idp_hstate_t st;
    logic [2:0] sync;
    logic sys_ok;
    logic cmd_ready;
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
    logic q_write;
    logic [5:0] q_tgt;
    logic [25:0] q_addr;
    logic [63:0] q_data;
    logic [8:0] q_be;
    logic [3:0] q_tag;
    logic q_ainc;
    logic ans_valid;
    logic ans_done;
    logic [63:0] ans_data;
    logic [1:0] ans_resp;
    logic [3:0] ans_id;
  } idp_host_t;

  function automatic logic tgt_known(input logic [5:0] t);
    return (t == TGT_DDR2) || (t == TGT_DESC) || (t == TGT_PHY) || (t == TGT_DISP);
  endfunction

  function automatic logic resp_good(input logic [1:0] r);
    return (r == RESP_OKAY) || (r == RESP_EXOKAY);
  endfunction
endpackage

/* logic/idp_if.sv */
interface idp_if;
  import idp_pkg::*;
  logic [ADDR_W-1:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic [31:0] rdata;

  modport dev (input addr, input wdata, input wr, input rd, output rdata);
  modport host (output addr, output wdata, output wr, output rd, input rdata);
endinterface

/* logic/idp_engine.sv */
module idp_engine
  import idp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,

  // Software register port
  idp_if.dev sw,

  // Internal target port
  output logic tgt_valid,
  output logic tgt_write,
  output logic [5:0] tgt_sel,
  output logic [25:0] tgt_addr,
  output logic [63:0] tgt_wdata,
  output logic [8:0] tgt_be,
  input wire logic tgt_resp_valid,
  input wire logic [63:0] tgt_rdata,
  input wire logic [1:0] tgt_resp,

  // RAM test mode
  output logic ram_test_mode
);

  idp_dev_t s_r;
  idp_dev_t s_nxt;

  assign sw.rdata = s_r.rdata;
  assign tgt_valid = s_r.tgt_valid;
  assign tgt_write = s_r.dir;
  assign tgt_sel = s_r.rsel;
  assign tgt_addr = s_r.addr;
  assign tgt_wdata = {s_r.high, s_r.low};
  assign tgt_be = s_r.be;
  assign ram_test_mode = s_r.testen; // see RULE4

  function automatic logic [31:0] sel_word(input idp_dev_t s);
    logic [31:0] w;
    w = '0;
    w[SEL_READY_BIT] = ~s.busy; // see RULE5
    w[SEL_DONE_BIT] = s.done;
    w[SEL_ID_LSB +: 4] = s.rid;
    w[SEL_RESP_LSB +: 2] = s.resp;
    w[SEL_TGT_LSB +: 6] = s.rsel;
    w[SEL_AINC_BIT] = s.ainc;
    w[SEL_TEST_BIT] = s.testen;
    return w;
  endfunction

  function automatic logic [31:0] cmd_word(input idp_dev_t s);
    logic [31:0] w;
    w = '0;
    w[CMD_BE_LSB +: 9] = s.be;
    w[CMD_TAG_LSB +: 4] = s.tag;
    w[CMD_DIR_BIT] = s.dir;
    return w;
  endfunction

  // Byte stride of one access; CSR targets move one word at a time.
  function automatic logic [25:0] step(input logic [5:0] t);
    return (t == TGT_DDR2) ? INC_DDR2 : INC_CSR;
  endfunction

  always_comb begin
    s_nxt = s_r;
    s_nxt.rdata = RST_WORD;

    // Register reads; unmapped addresses read as zero.
    if (sw.rd) begin
      case (sw.addr)
        OFS_SEL: begin
          s_nxt.rdata = sel_word(s_r);
        end
        OFS_CMD: begin
          s_nxt.rdata = cmd_word(s_r);
        end
        OFS_ADDR: begin
          s_nxt.rdata = {6'h00, s_r.addr};
        end
        OFS_LOW: begin
          s_nxt.rdata = s_r.low;
        end
        OFS_HIGH: begin
          s_nxt.rdata = s_r.high;
        end
        default: begin
          s_nxt.rdata = RST_WORD;
        end
      endcase
    end

    // Register writes only land while idle.
    if (sw.wr && !s_r.busy) begin // see RULE7
      case (sw.addr)
        OFS_SEL: begin
          s_nxt.testen = sw.wdata[SEL_TEST_BIT];
          s_nxt.ainc = sw.wdata[SEL_AINC_BIT];
          s_nxt.rsel = sw.wdata[SEL_TGT_LSB +: 6];
          if (sw.wdata[SEL_DONE_BIT]) begin
            s_nxt.done = 1'b0; // see RULE8
          end
        end
        OFS_CMD: begin
          s_nxt.be = sw.wdata[CMD_BE_LSB +: 9]; // see RULE15
          s_nxt.tag = sw.wdata[CMD_TAG_LSB +: 4];
          s_nxt.dir = sw.wdata[CMD_DIR_BIT]; // see RULE13
          s_nxt.busy = 1'b1; // see RULE20
          // Reserved codes never reach a target and end locally.
          s_nxt.tgt_valid = tgt_known(s_r.rsel); // see RULE11
        end
        OFS_ADDR: begin
          s_nxt.addr = sw.wdata[25:0]; // see RULE16
        end
        OFS_LOW: begin
          s_nxt.low = sw.wdata; // see RULE17
        end
        OFS_HIGH: begin
          s_nxt.high = sw.wdata; // see RULE19
        end
        default: begin
          s_nxt.rdata = s_nxt.rdata;
        end
      endcase
    end

    // Completion. Writes are locked out here, so a done set cannot meet a clear.
    if (s_r.busy && (tgt_resp_valid || !s_r.tgt_valid)) begin
      s_nxt.busy = 1'b0; // see RULE20
      s_nxt.tgt_valid = 1'b0;
      s_nxt.rid = s_r.tag; // see RULE9
      if (s_r.tgt_valid) begin
        s_nxt.resp = tgt_resp; // see RULE10
      end else begin
        s_nxt.resp = RESP_DECERR; // see RULE10
      end
      // Read data lands in the same edge that frees the port.
      if (s_r.tgt_valid && !s_r.dir) begin
        s_nxt.low = tgt_rdata[31:0]; // see RULE6
        s_nxt.high = tgt_rdata[63:32]; // see RULE19
      end
      if (s_r.tgt_valid && resp_good(tgt_resp)) begin
        s_nxt.done = 1'b1; // see RULE8
      end
      if (s_r.ainc) begin
        s_nxt.addr = s_r.addr + step(s_r.rsel); // see RULE12
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_r.busy <= 1'b0;
      s_r.tgt_valid <= 1'b0;
      s_r.testen <= 1'b0;
      s_r.ainc <= 1'b0;
      s_r.rsel <= TGT_DDR2;
      s_r.done <= 1'b0;
      s_r.rid <= 4'h0;
      s_r.resp <= RESP_OKAY;
      s_r.be <= 9'h000;
      s_r.tag <= 4'h0;
      s_r.dir <= 1'b0;
      s_r.addr <= RST_ADDR;
      s_r.low <= RST_WORD;
      s_r.high <= RST_WORD;
      s_r.rdata <= RST_WORD;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule // idp_engine

/* logic/idp_driver.sv */
// The plain strobed port is this design's own decision.
module idp_driver
  import idp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,

  // System clock status pin
  input wire logic sys_ready,

  // Register port towards the engine
  idp_if.host sw,

  // Command request
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [5:0] cmd_target,
  input wire logic [25:0] cmd_addr,
  input wire logic [63:0] cmd_data,
  input wire logic [8:0] cmd_be,
  input wire logic [3:0] cmd_tag,
  input wire logic cmd_ainc,
  output logic cmd_ready,

  // Answer
  output logic ans_valid,
  output logic ans_done,
  output logic [63:0] ans_data,
  output logic [1:0] ans_resp,
  output logic [3:0] ans_id
);

  idp_host_t h_r;
  idp_host_t h_nxt;

  assign sw.addr = h_r.addr;
  assign sw.wdata = h_r.wdata;
  assign sw.wr = h_r.wr;
  assign sw.rd = h_r.rd;
  assign cmd_ready = h_r.cmd_ready;
  assign ans_valid = h_r.ans_valid;
  assign ans_done = h_r.ans_done;
  assign ans_data = h_r.ans_data;
  assign ans_resp = h_r.ans_resp;
  assign ans_id = h_r.ans_id;

  function automatic logic [31:0] sel_value(input idp_host_t h, input logic clr);
    logic [31:0] w;
    w = '0;
    w[SEL_TEST_BIT] = 1'b1; // see RULE2 RULE3
    w[SEL_AINC_BIT] = h.q_ainc;
    w[SEL_TGT_LSB +: 6] = h.q_tgt;
    w[SEL_DONE_BIT] = clr;
    return w;
  endfunction

  always_comb begin
    h_nxt = h_r;
    h_nxt.wr = 1'b0;
    h_nxt.rd = 1'b0;
    h_nxt.ans_valid = 1'b0;
    h_nxt.sync = {h_r.sync[1:0], sys_ready};
    if (h_r.sync[2] == h_r.sync[1]) begin
      h_nxt.sys_ok = h_r.sync[2];
    end
    case (h_r.st)
      H_IDLE: begin
        // Test access only; nothing moves until the system clock runs.
        if (cmd_valid && h_r.cmd_ready) begin // see RULE1
          h_nxt.q_write = cmd_write;
          h_nxt.q_tgt = cmd_target;
          h_nxt.q_addr = cmd_addr;
          h_nxt.q_data = cmd_data;
          h_nxt.q_be = cmd_be;
          h_nxt.q_tag = cmd_tag;
          h_nxt.q_ainc = cmd_ainc;
          h_nxt.st = H_SEL;
        end
      end
      H_SEL: begin
        h_nxt.wr = 1'b1;
        h_nxt.addr = OFS_SEL;
        h_nxt.wdata = sel_value(h_r, 1'b0); // see RULE2
        h_nxt.st = H_ADDR;
      end
      H_ADDR: begin
        h_nxt.wr = 1'b1;
        h_nxt.addr = OFS_ADDR;
        h_nxt.wdata = {6'h00, h_r.q_addr}; // see RULE14
        h_nxt.st = H_LOW;
      end
      H_LOW: begin
        h_nxt.wr = 1'b1;
        h_nxt.addr = OFS_LOW;
        h_nxt.wdata = h_r.q_data[31:0]; // see RULE14
        h_nxt.st = H_HIGH;
      end
      H_HIGH: begin
        h_nxt.wr = 1'b1;
        h_nxt.addr = OFS_HIGH;
        h_nxt.wdata = h_r.q_data[63:32]; // see RULE19
        h_nxt.st = H_CMD;
      end
      H_CMD: begin
        h_nxt.wr = 1'b1;
        h_nxt.addr = OFS_CMD;
        h_nxt.wdata = {15'h0000, h_r.q_be, h_r.q_tag, 3'h0, h_r.q_write}; // see RULE13
        h_nxt.st = H_POLL;
      end
      H_POLL: begin
        h_nxt.rd = 1'b1;
        h_nxt.addr = OFS_SEL;
        h_nxt.st = H_PWAIT;
      end
      H_PWAIT: begin
        // Status stands only in the cycle after the strobe, so let the strobe pass first.
        if (h_r.rd) begin
          h_nxt.st = H_PWAIT;
        end else if (sw.rdata[SEL_READY_BIT]) begin // see RULE18
          h_nxt.ans_done = sw.rdata[SEL_DONE_BIT];
          h_nxt.ans_resp = sw.rdata[SEL_RESP_LSB +: 2];
          h_nxt.ans_id = sw.rdata[SEL_ID_LSB +: 4];
          h_nxt.st = h_r.q_write ? H_FIN : H_RLOW;
        end else begin
          h_nxt.st = H_POLL;
        end
      end
      H_RLOW: begin
        h_nxt.rd = 1'b1;
        h_nxt.addr = OFS_LOW;
        h_nxt.st = H_RHIGH;
      end
      H_RHIGH: begin
        h_nxt.rd = 1'b1;
        h_nxt.addr = OFS_HIGH;
        h_nxt.st = H_RLAST;
      end
      H_RLAST: begin
        h_nxt.ans_data[31:0] = sw.rdata;
        h_nxt.st = H_FIN;
      end
      H_FIN: begin
        if (!h_r.q_write) begin
          h_nxt.ans_data[63:32] = sw.rdata;
        end
        h_nxt.wr = 1'b1;
        h_nxt.addr = OFS_SEL;
        h_nxt.wdata = sel_value(h_r, 1'b1); // see RULE8
        h_nxt.ans_valid = 1'b1;
        h_nxt.st = H_IDLE;
      end
      default: begin
        h_nxt.st = H_IDLE;
      end
    endcase
    h_nxt.cmd_ready = (h_nxt.st == H_IDLE) && h_nxt.sys_ok && !(cmd_valid && h_r.cmd_ready);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      h_r <= '0;
    end else begin
      h_r <= h_nxt;
    end
  end

endmodule // idp_driver

/* test/idp_asserts.sv */
module idp_asserts
  import idp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] seen_r;
  logic dir_r;
  logic cmd_wr;

  assign cmd_wr = wr && addr == OFS_CMD;

  // Tracks address and low-word loads since the last command, so a command sent on a stale address or low word is caught.
  always_ff @(posedge clk) begin
    if (rst || cmd_wr) begin
      seen_r <= 2'h0;
    end else if (wr && addr == OFS_ADDR) begin
      seen_r[0] <= 1'b1;
    end else if (wr && addr == OFS_LOW) begin
      seen_r[1] <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dir_r <= 1'b0;
    end else if (cmd_wr) begin
      dir_r <= wdata[CMD_DIR_BIT];
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  AST_ONE_STROBE: assert property (
    !(wr && rd)) else $error("read and write strobes together");
  AST_RDATA_IDLE: assert property (
    !$past(rd) |-> rdata == 32'h0) else $error("read data outside its cycle");
  AST_SEL_RSVD: assert property (
    $past(rd) && $past(addr) == OFS_SEL |-> rdata[29:24] == 6'h0 && rdata[19:18] == 2'h0
      && rdata[15:10] == 6'h0 && rdata[3:2] == 2'h0) else $error("reserved status bits set");
  AST_TEST_SET: assert property (
    wr && addr == OFS_SEL |-> wdata[SEL_TEST_BIT]) else $error("test mode not enabled");
  AST_LOAD_FIRST: assert property (
    cmd_wr |-> seen_r == 2'h3) else $error("command before address and data");
  AST_CMD_RSVD: assert property (
    cmd_wr |-> wdata[31:17] == 15'h0 && wdata[3:1] == 3'h0) else $error("command reserved bits");
  AST_POLL: assert property (
    cmd_wr |=> rd && addr == OFS_SEL) else $error("no status poll after command");
  AST_BUSY_HOLD: assert property (
    $past(rd) && $past(addr) == OFS_SEL && !rdata[SEL_READY_BIT] |-> (!wr) [*2])
    else $error("write while port busy");
  AST_READ_FETCH: assert property (
    $past(rd) && $past(addr) == OFS_SEL && rdata[SEL_READY_BIT] && !dir_r
      |-> ##[0:2] (rd && addr == OFS_LOW)) else $error("read result not fetched");
endmodule // idp_asserts

/* test/tb_indirect_ram_data_port.sv */
module tb_indirect_ram_data_port;
  timeunit 1ns;
  timeprecision 100ps;
  import idp_pkg::*;

  logic clk, rst, sys_ready;
  logic cmd_valid, cmd_write, cmd_ainc, cmd_ready, ans_valid, ans_done;
  logic [5:0] cmd_target;
  logic [25:0] cmd_addr;
  logic [63:0] cmd_data, ans_data, tgt_wdata, tgt_rdata;
  logic [8:0] cmd_be, tgt_be;
  logic [3:0] cmd_tag, ans_id;
  logic [1:0] ans_resp, tgt_resp;
  logic tgt_valid, tgt_write, tgt_resp_valid, ram_test_mode;
  logic [5:0] tgt_sel;
  logic [25:0] tgt_addr;
  logic [105:0] cap;
  logic [5:0] tl [4] = '{TGT_DESC, TGT_PHY, TGT_DISP, TGT_DDR2};
  int dly = 0, cnt = 0, npulse = 0, n0 = 0, cycles = 0, n_errors = 0, tests_run = 0;

  idp_if sw_bus ();

  idp_engine i_idp_engine (.clk(clk), .rst(rst), .sw(sw_bus), .tgt_valid(tgt_valid),
    .tgt_write(tgt_write), .tgt_sel(tgt_sel), .tgt_addr(tgt_addr), .tgt_wdata(tgt_wdata),
    .tgt_be(tgt_be), .tgt_resp_valid(tgt_resp_valid), .tgt_rdata(tgt_rdata),
    .tgt_resp(tgt_resp), .ram_test_mode(ram_test_mode));

  idp_driver i_idp_driver (.clk(clk), .rst(rst), .sys_ready(sys_ready), .sw(sw_bus),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_target(cmd_target),
    .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_be(cmd_be), .cmd_tag(cmd_tag),
    .cmd_ainc(cmd_ainc), .cmd_ready(cmd_ready), .ans_valid(ans_valid), .ans_done(ans_done),
    .ans_data(ans_data), .ans_resp(ans_resp), .ans_id(ans_id));

  idp_asserts i_idp_asserts (.clk(clk), .rst(rst), .addr(sw_bus.addr),
    .wdata(sw_bus.wdata), .wr(sw_bus.wr), .rd(sw_bus.rd), .rdata(sw_bus.rdata));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Target answers dly cycles after it first sees a request, so prompt and slow both occur.
  always @(posedge clk) begin
    tgt_resp_valid <= 1'b0;
    cycles <= cycles + 1;
    if (rst || tgt_valid !== 1'b1) begin
      cnt <= 0;
    end else if (!tgt_resp_valid) begin
      cnt <= cnt + 1;
      if (cnt == dly) begin
        tgt_resp_valid <= 1'b1;
        cap <= {tgt_write, tgt_sel, tgt_addr, tgt_wdata, tgt_be};
        npulse <= npulse + 1;
      end
    end
    if (cycles == 20000) begin
      n_errors++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("errors %0d comparisons %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic run(input logic [110:0] c);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 300) begin
      @(posedge clk);
      #1;
      n++;
    end
    @(posedge clk);
    cmd_valid <= 1'b1;
    {cmd_write, cmd_target, cmd_addr, cmd_data, cmd_be, cmd_tag, cmd_ainc} <= c;
    @(posedge clk);
    cmd_valid <= 1'b0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (ans_valid !== 1'b1 && n < 600);
    chk(n < 600, 1'b1);
  endtask

  initial begin
    rst = 1'b1;
    sys_ready = 1'b1;
    cmd_valid = 1'b0;
    {cmd_write, cmd_target, cmd_addr, cmd_data, cmd_be, cmd_tag, cmd_ainc} = '0;
    tgt_rdata = 64'hfedcba9876543210;
    tgt_resp = RESP_OKAY;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    run({1'b1, TGT_DDR2, 26'h3fffff8, 64'h0123456789abcdef, 9'h1a5, 4'h3, 1'b1});
    chk(cap, {1'b1, TGT_DDR2, 26'h3fffff8, 64'h0123456789abcdef, 9'h1a5});
    chk({ans_done, ans_resp, ans_id}, {1'b1, RESP_OKAY, 4'h3});
    chk(ram_test_mode, 1'b1);
    chk(tgt_addr, 26'h0000000);
    dly = 20;
    run({1'b0, TGT_DDR2, 26'h0000010, 64'h0, 9'h0, 4'hc, 1'b0});
    chk(cap[105:73], {1'b0, TGT_DDR2, 26'h0000010});
    chk(ans_data, 64'hfedcba9876543210);
    chk(tgt_addr, 26'h0000010);
    for (int i = 0; i < 4; i++) begin
      tgt_resp <= 2'(i);
      dly = 3 * i;
      run({1'b0, tl[i], 26'(8 * i), 64'h0, 9'h0, 4'(i + 4), 1'(i == 1)});
      chk(tgt_addr, 26'(8 * i) + (i == 1 ? INC_CSR : 26'h0));
      chk({ans_done, ans_resp, ans_id}, {1'(i < 2), 2'(i), 4'(i + 4)});
      chk(cap[104:99], tl[i]);
    end
    n0 = npulse;
    run({1'b0, 6'h01, 26'h0, 64'h0, 9'h0, 4'h9, 1'b0});
    chk(npulse - n0, 0);
    chk({ans_done, ans_resp, ans_id}, {1'b0, RESP_DECERR, 4'h9});
    wrap_up();
  end
endmodule // tb_indirect_ram_data_port
